// ==== port_c_pin_data_pkg.sv ====
/*
  shared constants and carrier types for the 8-bit general-purpose port
  with peripheral pin multiplexing.
  assumes a single 100 MHz system clock and an AHB-Lite register bus.
*/
package port_c_pin_data_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses of aligned 32-bit words)
  // ---------------------------------------------------------------
  localparam logic [7:0] PIN_DATA_OFS   = 8'h00;
  localparam logic [7:0] LATCH_OFS      = 8'h04;
  localparam logic [7:0] DIR_OFS        = 8'h08;
  localparam logic [7:0] OVR_STATUS_OFS = 8'h0c;

  // ---------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------
  localparam int          PORT_WIDTH     = 8;
  localparam logic [7:0]  DIR_RESET      = 8'hff;
  localparam logic [7:0]  LATCH_RESET    = 8'h00;
  localparam logic        PIN_SEL_ERASED = 1'b1;
  localparam logic [23:0] RDATA_PAD      = 24'h00_0000;

  // ---------------------------------------------------------------
  // pin positions of the shared functions
  // ---------------------------------------------------------------
  localparam int OSC_OUT_BIT = 0;
  localparam int OSC_IN_BIT  = 1;
  localparam int CMP2_BIT    = 1;
  localparam int CMP1_BIT    = 2;
  localparam int SCK_BIT     = 3;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic osc_en;
    logic cmp1_out;
    logic cmp1_out_en;
    logic cmp2_out;
    logic cmp2_out_en;
    logic epwm_a;
    logic epwm_en;
    logic epwm_shutdown;
    logic epwm_sd_tristate;
    logic spi_master;
    logic spi_sck;
  } periph_in_type;

  typedef struct packed {
    logic capture1;
    logic capture2;
    logic counter_clk;
    logic sck_in;
    logic osc_active;
  } periph_out_type;

endpackage

// ==== port_pin_cell.sv ====
/*
  one pin of the port: picks driver enable and level from direction,
  latch and the peripheral overrides.
  assumes the caller registers both outputs before they reach a pad.
*/
`timescale 1ns/1ps

module port_pin_cell (
  input  wire logic dir_i,
  input  wire logic latch_i,
  input  wire logic alt_sel_i,
  input  wire logic alt_i,
  input  wire logic force_out_i,
  input  wire logic force_hiz_i,
  output logic      oe_o,
  output logic      out_o
);

  // ---------------------------------------------------------------
  // driver select
  // ---------------------------------------------------------------
  // tristate beats any forced output, forced output beats the dir bit
  always_comb begin
    oe_o  = ~force_hiz_i & (force_out_i | ~dir_i); // [RULE2] [RULE4]
    out_o = alt_sel_i ? alt_i : latch_i;           // peripheral wins
  end

endmodule // port_pin_cell

// ==== ahb_front.sv ====
/*
  AHB-Lite slave front end: takes the address phase, raises a read
  strobe in it and a write strobe in the following data phase.
  assumes single word transfers and zero wait states.
*/
`timescale 1ns/1ps

module ahb_front (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       hsel_i,
  input  wire logic [7:0] haddr_i,
  input  wire logic [1:0] htrans_i,
  input  wire logic       hwrite_i,
  input  wire logic       hready_i,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      wr_addr_o
);

  typedef struct packed {
    logic       wr_pend;
    logic [7:0] addr;
  } ahb_state_type;

  ahb_state_type s_r;
  ahb_state_type s_nxt;
  logic          take;

  // ---------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------
  always_comb begin
    take        = hsel_i & htrans_i[1] & hready_i;
    rd_o        = take & ~hwrite_i;
    s_nxt       = s_r;
    s_nxt.wr_pend = take & hwrite_i;
    s_nxt.addr  = take ? haddr_i : s_r.addr;
  end

  // low enable freezes the pending write as well
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  assign wr_o      = s_r.wr_pend;
  assign wr_addr_o = s_r.addr;

endmodule // ahb_front

// ==== port_c_pin_data_top.sv ====
/*
  8-bit bidirectional port with per-pin direction, output latch and
  multiplexing with oscillator, compare/capture, enhanced PWM and
  serial clock functions; registers reached over AHB-Lite.
  assumes pads resolve level from PIN_OE_O and PIN_OUT_O, and that
  peripheral controls are synchronous to SYS_CLK_I.
*/
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps

// Contract
// RULE1 - eight pins, each with its own direction and latch bit
// RULE2 - direction 1 floats the pin, direction 0 drives latch data
// RULE3 - latch register reads back latched value, not pin levels
// RULE4 - enabled peripheral may force a pin output or input
// RULE5 - direction reads return stored bits despite overrides
// RULE6 - after reset every pin is a digital input
// RULE7 - second compare unit uses bit 1 only when pin-select is 1
// RULE8 - oscillator enabled takes bits 0 and 1 off digital i/o
// RULE9 - bit 1 carries second compare output or feeds its capture
// RULE10 - bit 2 carries first compare output or feeds its capture
// RULE11 - bit 2 carries PWM channel A, may float on shutdown
// RULE12 - SPI master with direction 0 drives its clock on bit 3
// RULE13 - pin data reads pin levels, writes go to the latch
module port_c_pin_data_top
  #(parameter int WIDTH = port_c_pin_data_pkg::PORT_WIDTH)
(
  input  wire logic                     SYS_CLK_I,
  input  wire logic                     RESET_N_I,
  input  wire logic                     CLK_EN_I,
  input  wire logic                     HSEL_I,
  input  wire logic [31:0]              HADDR_I,
  input  wire logic [1:0]               HTRANS_I,
  input  wire logic                     HWRITE_I,
  input  wire logic [2:0]               HSIZE_I,
  input  wire logic [31:0]              HWDATA_I,
  input  wire logic                     HREADY_I,
  output logic      [31:0]              HRDATA_O,
  output logic                          HREADYOUT_O,
  output logic                          HRESP_O,
  input  wire logic                     SECOND_CMP_PIN_SELECT_I,
  input  wire port_c_pin_data_pkg::periph_in_type PERIPH_I,
  output port_c_pin_data_pkg::periph_out_type     PERIPH_O,
  input  wire logic [WIDTH-1:0]         PIN_IN_I,
  output logic      [WIDTH-1:0]         PIN_OUT_O,
  output logic      [WIDTH-1:0]         PIN_OE_O
);

  import port_c_pin_data_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] dir;
    logic             pin_sel;
    logic             sel_loaded;
    logic [WIDTH-1:0] pin_out;
    logic [WIDTH-1:0] pin_oe;
    logic [7:0]       rdata;
    logic             ready;
    periph_out_type   po;
  } port_state_type;

  port_state_type   s_r;
  port_state_type   s_nxt;

  logic             rd;
  logic             wr;
  logic [7:0]       wr_addr;
  logic [WIDTH-1:0] alt_sel;
  logic [WIDTH-1:0] alt;
  logic [WIDTH-1:0] fout;
  logic [WIDTH-1:0] fhiz;
  logic [WIDTH-1:0] cell_oe;
  logic [WIDTH-1:0] cell_out;
  logic [WIDTH-1:0] pin_read;
  logic             cmp2_here;

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  ahb_front u_bus (
    .clk_i     (SYS_CLK_I),
    .rst_n_i   (RESET_N_I),
    .clk_en_i  (CLK_EN_I),
    .hsel_i    (HSEL_I),
    .haddr_i   (HADDR_I[7:0]),
    .htrans_i  (HTRANS_I),
    .hwrite_i  (HWRITE_I),
    .hready_i  (HREADY_I),
    .rd_o      (rd),
    .wr_o      (wr),
    .wr_addr_o (wr_addr)
  );

  // ---------------------------------------------------------------
  // peripheral overrides per pin
  // ---------------------------------------------------------------
  // only bits 0..3 are shared; upper pins stay plain port pins
  always_comb begin
    alt_sel   = '0;
    alt       = '0;
    fout      = '0;
    fhiz      = '0;
    cmp2_here = s_r.pin_sel & PERIPH_I.cmp2_out_en;          // [RULE7]
    // oscillator owns both pins regardless of direction
    fhiz[OSC_OUT_BIT] = PERIPH_I.osc_en;                      // [RULE8]
    fhiz[OSC_IN_BIT]  = PERIPH_I.osc_en;                      // [RULE8]
    // second compare output replaces latch data on bit 1
    alt_sel[CMP2_BIT] = cmp2_here;                            // [RULE9]
    alt[CMP2_BIT]     = PERIPH_I.cmp2_out;
    // pwm channel a first, then first compare output, on bit 2
    alt_sel[CMP1_BIT] = PERIPH_I.epwm_en | PERIPH_I.cmp1_out_en; // [RULE10]
    alt[CMP1_BIT]     = PERIPH_I.epwm_en ? PERIPH_I.epwm_a
                                         : PERIPH_I.cmp1_out; // [RULE11]
    fout[CMP1_BIT]    = PERIPH_I.epwm_en;                     // [RULE4]
    fhiz[CMP1_BIT]    = PERIPH_I.epwm_en & PERIPH_I.epwm_shutdown
                        & PERIPH_I.epwm_sd_tristate;          // [RULE11]
    // serial clock drives bit 3 only in master mode
    alt_sel[SCK_BIT]  = PERIPH_I.spi_master;                  // [RULE12]
    alt[SCK_BIT]      = PERIPH_I.spi_sck;
  end

  // ---------------------------------------------------------------
  // pin cells
  // ---------------------------------------------------------------
  // one identical cell per pin keeps every pin separately steerable
  for (genvar g = 0; g < WIDTH; g++) begin : g_pin                // [RULE1]
    port_pin_cell u_cell (
      .dir_i       (s_r.dir[g]),
      .latch_i     (s_r.latch[g]),
      .alt_sel_i   (alt_sel[g]),
      .alt_i       (alt[g]),
      .force_out_i (fout[g]),
      .force_hiz_i (fhiz[g]),
      .oe_o        (cell_oe[g]),
      .out_o       (cell_out[g])
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // strap caught once after reset release, never under reset
    if (!s_r.sel_loaded) begin
      s_nxt.pin_sel    = SECOND_CMP_PIN_SELECT_I;             // [RULE7]
      s_nxt.sel_loaded = 1'b1;
    end
    // data phase writes; pin data writes land in the latch
    if (wr) begin
      case (wr_addr)
        PIN_DATA_OFS: s_nxt.latch = HWDATA_I[WIDTH-1:0];     // [RULE13]
        LATCH_OFS:    s_nxt.latch = HWDATA_I[WIDTH-1:0];     // [RULE3]
        DIR_OFS:      s_nxt.dir   = HWDATA_I[WIDTH-1:0];
        default:      s_nxt.latch = s_r.latch;              // ignored
      endcase
    end
    // oscillator pins read as zero, digital input is cut off
    pin_read = PIN_IN_I;
    if (PERIPH_I.osc_en) begin
      pin_read[OSC_OUT_BIT] = 1'b0;                           // [RULE8]
      pin_read[OSC_IN_BIT]  = 1'b0;
    end
    // read data from next values so a write right before is seen
    s_nxt.rdata = 8'h00;
    if (rd) begin
      case (HADDR_I[7:0])
        PIN_DATA_OFS:   s_nxt.rdata = pin_read;               // [RULE13]
        LATCH_OFS:      s_nxt.rdata = s_nxt.latch;            // [RULE3]
        DIR_OFS:        s_nxt.rdata = s_nxt.dir;              // [RULE5]
        OVR_STATUS_OFS: s_nxt.rdata = fout | fhiz | alt_sel;
        default:        s_nxt.rdata = 8'h00;
      endcase
    end
    s_nxt.ready  = 1'b1;
    s_nxt.pin_oe = cell_oe;                                   // [RULE2]
    s_nxt.pin_out = cell_out;
    // capture and clock inputs see the pin only while it listens
    s_nxt.po.capture1    = s_r.dir[CMP1_BIT] & PIN_IN_I[CMP1_BIT];  // [RULE10]
    s_nxt.po.capture2    = s_r.pin_sel & ~PERIPH_I.osc_en
                           & s_r.dir[CMP2_BIT] & PIN_IN_I[CMP2_BIT]; // [RULE9]
    s_nxt.po.counter_clk = ~PERIPH_I.osc_en & s_r.dir[0] & PIN_IN_I[0];
    s_nxt.po.sck_in      = s_r.dir[SCK_BIT] & PIN_IN_I[SCK_BIT];
    s_nxt.po.osc_active  = PERIPH_I.osc_en;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset leaves every pin an undriven digital input
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_r            <= '0;
      s_r.dir        <= DIR_RESET;                            // [RULE6]
      s_r.latch      <= LATCH_RESET;
      s_r.pin_sel    <= PIN_SEL_ERASED;
      s_r.ready      <= 1'b1;
    end else if (CLK_EN_I) begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the slave never errors, so the response is a fixed OKAY
  assign HRDATA_O    = {RDATA_PAD, s_r.rdata};
  assign HREADYOUT_O = s_r.ready;
  assign HRESP_O     = 1'b0;
  assign PIN_OE_O    = s_r.pin_oe;
  assign PIN_OUT_O   = s_r.pin_out;
  assign PERIPH_O    = s_r.po;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking

  logic plain_step;
  assign plain_step = CLK_EN_I & ~wr;

  a_reset_all_inputs: assert property ( // [RULE6]
    !RESET_N_I ##1 !RESET_N_I |-> (PIN_OE_O == '0) && (s_r.dir == DIR_RESET))
    else $error("pins not inputs during reset");

  a_plain_pin_drive: assert property ( // [RULE2]
    disable iff (!RESET_N_I)
    CLK_EN_I |=> (PIN_OE_O[7] == !$past(s_r.dir[7]))
                 && (PIN_OUT_O[7] == $past(s_r.latch[7])))
    else $error("pin 7 does not follow dir and latch");

  a_latch_write_back: assert property ( // [RULE3]
    disable iff (!RESET_N_I)
    (CLK_EN_I && wr && wr_addr == LATCH_OFS) ##1 !(CLK_EN_I && wr)
    ##1 (CLK_EN_I && rd && HADDR_I[7:0] == LATCH_OFS)
    |=> HRDATA_O[7:0] == $past(HWDATA_I[7:0], 3))
    else $error("latch read does not return written value");

  a_pin_data_read: assert property ( // [RULE13]
    disable iff (!RESET_N_I)
    (CLK_EN_I && rd && HADDR_I[7:0] == PIN_DATA_OFS && !PERIPH_I.osc_en)
    |=> HRDATA_O == {RDATA_PAD, $past(PIN_IN_I)})
    else $error("pin data read is not pin level");

  a_dir_read_stored: assert property ( // [RULE5]
    disable iff (!RESET_N_I)
    (plain_step && rd && HADDR_I[7:0] == DIR_OFS && PERIPH_I.epwm_en)
    |=> HRDATA_O[7:0] == $past(s_r.dir))
    else $error("direction read altered by override");

  a_osc_float: assert property ( // [RULE8]
    disable iff (!RESET_N_I)
    (CLK_EN_I && PERIPH_I.osc_en) |=> !PIN_OE_O[0] && !PIN_OE_O[1])
    else $error("oscillator pins still driven");

  a_cmp2_drive: assert property ( // [RULE9]
    disable iff (!RESET_N_I)
    (CLK_EN_I && !PERIPH_I.osc_en && s_r.pin_sel
     && PERIPH_I.cmp2_out_en && !s_r.dir[1])
    |=> PIN_OE_O[1] && PIN_OUT_O[1] == $past(PERIPH_I.cmp2_out))
    else $error("bit 1 lacks second compare output");

  a_cmp2_elsewhere: assert property ( // [RULE7]
    disable iff (!RESET_N_I)
    (CLK_EN_I && !PERIPH_I.osc_en && !s_r.pin_sel && !s_r.dir[1])
    |=> PIN_OUT_O[1] == $past(s_r.latch[1]) && !PERIPH_O.capture2)
    else $error("bit 1 used by unit moved away");

  a_cmp1_drive: assert property ( // [RULE10]
    disable iff (!RESET_N_I)
    (CLK_EN_I && !PERIPH_I.epwm_en && PERIPH_I.cmp1_out_en && !s_r.dir[2])
    |=> PIN_OE_O[2] && PIN_OUT_O[2] == $past(PERIPH_I.cmp1_out))
    else $error("bit 2 lacks first compare output");

  a_epwm_force_out: assert property ( // [RULE4]
    disable iff (!RESET_N_I)
    (CLK_EN_I && PERIPH_I.epwm_en && !PERIPH_I.epwm_shutdown)
    |=> PIN_OE_O[2] && PIN_OUT_O[2] == $past(PERIPH_I.epwm_a))
    else $error("pwm channel a not forced out");

  a_epwm_shut_float: assert property ( // [RULE11]
    disable iff (!RESET_N_I)
    (CLK_EN_I && PERIPH_I.epwm_en && PERIPH_I.epwm_shutdown
     && PERIPH_I.epwm_sd_tristate) |=> !PIN_OE_O[2])
    else $error("bit 2 driven during shutdown");

  a_sck_drive: assert property ( // [RULE12]
    disable iff (!RESET_N_I)
    (CLK_EN_I && PERIPH_I.spi_master && !s_r.dir[3])
    |=> PIN_OE_O[3] && PIN_OUT_O[3] == $past(PERIPH_I.spi_sck))
    else $error("bit 3 lacks serial clock");

  a_pins_separate: assert property ( // [RULE1]
    disable iff (!RESET_N_I)
    CLK_EN_I |=> PIN_OE_O[WIDTH-1:4] == ~$past(s_r.dir[WIDTH-1:4]))
    else $error("upper pins not individually steered");

  a_capture1_listen: assert property ( // [RULE10]
    disable iff (!RESET_N_I)
    (RESET_N_I && CLK_EN_I)
    |=> PERIPH_O.capture1 == ($past(s_r.dir[CMP1_BIT]) & $past(PIN_IN_I[CMP1_BIT])))
    else $error("first capture input not gated by direction");

  a_cmp2_capture: assert property ( // [RULE9]
    disable iff (!RESET_N_I)
    (RESET_N_I && CLK_EN_I && !PERIPH_I.osc_en && s_r.pin_sel && s_r.dir[CMP2_BIT])
    |=> !PIN_OE_O[CMP2_BIT] && PERIPH_O.capture2 == $past(PIN_IN_I[CMP2_BIT]))
    else $error("bit 1 does not feed second capture input");

  a_osc_capture_cut: assert property ( // [RULE8]
    disable iff (!RESET_N_I)
    (CLK_EN_I && PERIPH_I.osc_en) |=> !PERIPH_O.capture2 && !PERIPH_O.counter_clk)
    else $error("oscillator pins still reach digital inputs");

  a_read_idle_zero: assert property ( // [RULE13]
    disable iff (!RESET_N_I)
    (CLK_EN_I && !rd) |=> HRDATA_O == '0)
    else $error("read data not cleared outside a read");

  a_pin_write_latch: assert property ( // [RULE13]
    disable iff (!RESET_N_I)
    (CLK_EN_I && wr && wr_addr == PIN_DATA_OFS)
    |=> s_r.latch == $past(HWDATA_I[WIDTH-1:0]))
    else $error("pin data write missed the latch");

  a_dir_write_lands: assert property ( // [RULE2]
    disable iff (!RESET_N_I)
    (CLK_EN_I && wr && wr_addr == DIR_OFS)
    |=> s_r.dir == $past(HWDATA_I[WIDTH-1:0]))
    else $error("direction write lost");

  a_sck_input: assert property ( // [RULE12]
    disable iff (!RESET_N_I)
    (CLK_EN_I && PERIPH_I.spi_master && s_r.dir[SCK_BIT]) |=> !PIN_OE_O[SCK_BIT])
    else $error("bit 3 driven while set as input");

  c_latch_write: cover property (
    disable iff (!RESET_N_I) CLK_EN_I && wr && wr_addr == LATCH_OFS);
  c_osc_on: cover property (
    disable iff (!RESET_N_I) CLK_EN_I && PERIPH_I.osc_en);
  c_pwm_shutdown: cover property (
    disable iff (!RESET_N_I)
    PERIPH_I.epwm_en && PERIPH_I.epwm_shutdown && PERIPH_I.epwm_sd_tristate);
  c_sck_master: cover property (
    disable iff (!RESET_N_I) PERIPH_I.spi_master && !s_r.dir[3]);
  c_enable_low: cover property (
    disable iff (!RESET_N_I) !CLK_EN_I && PERIPH_I.osc_en);

endmodule // port_c_pin_data_top

// ==== port_c_pin_data_board_model.sv ====
/*
  board-side model of the eight pads: resolves each pad level from the
  port's drive and from what the board drives onto an undriven pad.
  assumes the bench sets drive_en_i / drive_lvl_i on rising clock edges.
*/
`timescale 1ns/1ps

module port_c_pin_data_board_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_out_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] drive_en_i,
  input  wire logic [7:0] drive_lvl_i,
  output logic      [7:0] pin_in_o
);
  // ---------------------------------------------------------------
  // floating pads
  // ---------------------------------------------------------------
  logic [7:0] float_r;

  // no pull-ups on the board, so a floating pad flips every cycle
  // instead of holding a level the simulator would pick for us
  initial float_r = 8'h55;
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end

  // port drive wins; contention is not modelled
  always_comb begin
    pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & drive_en_i & drive_lvl_i)
             | (~pin_oe_i & ~drive_en_i & float_r);
  end
endmodule // port_c_pin_data_board_model

// ==== port_c_gpio_with_pin_mux_bench.sv ====
/*
  self-checking bench for the port with pin multiplexing: registers over
  AHB-Lite, peripherals as struct levels, pads through the board model.
  assumes zero-wait bus answers and pins one edge after the registers.
*/
`timescale 1ns/1ps

module port_c_gpio_with_pin_mux_bench;
  import port_c_pin_data_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic           sys_clk, reset_n, strap, hsel, hwrite, hreadyout, hresp, clk_en;
  logic [1:0]     htrans;
  logic [31:0]    haddr, hwdata, hrdata;
  logic [7:0]     pin_in, pin_out, pin_oe, ext_en, ext_lvl;
  periph_in_type  periph;
  periph_out_type periph_out;
  int             mismatches, check_count;

  // clock and time-zero input values
  initial begin
    sys_clk = 1'b0; reset_n = 1'b0; strap = 1'b1; hsel = 1'b0; hwrite = 1'b0;
    htrans = 2'b00; haddr = '0; hwdata = '0; periph = '0; ext_en = '0; ext_lvl = '0;
    mismatches = 0; check_count = 0; clk_en = 1'b1;
  end
  always #5 sys_clk = ~sys_clk;

  // hreadyout doubles as the bus hready, single slave
  port_c_pin_data_top dut_u (.SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .CLK_EN_I(clk_en),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
    .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .SECOND_CMP_PIN_SELECT_I(strap),
    .PERIPH_I(periph), .PERIPH_O(periph_out), .PIN_IN_I(pin_in),
    .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe));

  port_c_pin_data_board_model board_u (.clk_i(sys_clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .drive_en_i(ext_en), .drive_lvl_i(ext_lvl), .pin_in_o(pin_in));

  // ---------------------------------------------------------------
  // report and compare
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_reg({31'h0, got}, {31'h0, exp}, m);
  endtask

  // ---------------------------------------------------------------
  // bus and stimulus helpers
  // ---------------------------------------------------------------
  // a missing hready would hang the run, so every wait is capped
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        $display("[ERR] %0t bus wait timed out", $time);
        print_verdict();
      end
      @(posedge sys_clk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h00_0000, ofs};
    wait_ready();
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, ofs, {24'h00_0000, d}, rd);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'b0, ofs, 32'h0000_0000, rd);
    chk_reg(rd, {24'h00_0000, exp}, "register read");
  endtask

  // pins follow registers and peripheral inputs one edge later
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic set_per(input periph_in_type p);
    @(posedge sys_clk);
    periph <= p;
    settle();
  endtask

  task automatic drive(input logic [7:0] en, input logic [7:0] lvl);
    @(posedge sys_clk);
    ext_en <= en; ext_lvl <= lvl;
    settle();
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk_reg({24'h0, pin_oe}, 32'h0, "oe after reset");
    rd_chk(DIR_OFS, 8'hff);
    rd_chk(LATCH_OFS, 8'h00);
    rd_chk(8'h10, 8'h00);
    chk_bit(hresp, 1'b0, "okay response");
  endtask

  task automatic t_drive();
    wr(LATCH_OFS, 8'ha5);
    wr(DIR_OFS, 8'h0f);
    settle();
    chk_reg({24'h0, pin_oe}, 32'hf0, "oe per dir");
    chk_reg({24'h0, pin_out & 8'hf0}, 32'ha0, "out per latch");
    wr(DIR_OFS, 8'hf0);
    wr(LATCH_OFS, 8'h5a);
    settle();
    chk_reg({24'h0, pin_oe}, 32'h0f, "oe per pin");
    chk_reg({24'h0, pin_out & 8'h0f}, 32'h0a, "out per pin");
  endtask

  task automatic t_latch();
    wr(DIR_OFS, 8'hff);
    drive(8'hff, 8'h3c);
    wr(PIN_DATA_OFS, 8'hc3);
    rd_chk(LATCH_OFS, 8'hc3);
    rd_chk(PIN_DATA_OFS, 8'h3c);
    wr(LATCH_OFS, 8'h96);
    rd_chk(LATCH_OFS, 8'h96);
  endtask

  task automatic t_osc();
    periph_in_type p;
    p = '0;
    drive(8'h00, 8'h00);
    wr(LATCH_OFS, 8'hff);
    wr(DIR_OFS, 8'h00);
    p.osc_en = 1'b1;
    set_per(p);
    chk_reg({24'h0, pin_oe}, 32'hfc, "osc frees bits 0,1");
    chk_bit(periph_out.osc_active, 1'b1, "osc active");
    rd_chk(DIR_OFS, 8'h00);
    rd_chk(PIN_DATA_OFS, 8'hfc);
    set_per('0);
    wr(DIR_OFS, 8'hff);
    drive(8'h01, 8'h01);
    chk_bit(periph_out.counter_clk, 1'b1, "counter input");
  endtask

  // strap only takes effect through a reset, so this also covers a mid-run reset
  task automatic t_cmp(input logic sel);
    periph_in_type p;
    p = '0;
    @(posedge sys_clk);
    strap <= sel;
    do_reset();
    drive(8'h00, 8'h00);
    p.cmp2_out_en = 1'b1; p.cmp2_out = 1'b1; p.cmp1_out_en = 1'b1; p.cmp1_out = 1'b1;
    set_per(p);
    wr(DIR_OFS, 8'h00);
    settle();
    chk_reg({24'h0, pin_out}, {29'h0, 1'b1, sel, 1'b0}, "compare outs");
    wr(DIR_OFS, 8'h06);
    drive(8'h06, 8'h06);
    chk_bit(periph_out.capture1, 1'b1, "capture1");
    chk_bit(periph_out.capture2, sel, "capture2");
    set_per('0);
  endtask

  task automatic t_pwm();
    periph_in_type p;
    p = '0;
    drive(8'h00, 8'h00);
    wr(DIR_OFS, 8'hff);
    wr(LATCH_OFS, 8'h00);
    p.epwm_en = 1'b1; p.epwm_a = 1'b1;
    set_per(p);
    chk_reg({24'h0, pin_oe}, 32'h04, "pwm forces out");
    chk_bit(pin_out[2], 1'b1, "pwm level");
    p.epwm_shutdown = 1'b1; p.epwm_sd_tristate = 1'b1;
    set_per(p);
    chk_reg({24'h0, pin_oe}, 32'h00, "shutdown floats");
    rd_chk(DIR_OFS, 8'hff);
    rd_chk(OVR_STATUS_OFS, 8'h04);
    set_per('0);
  endtask

  task automatic t_spi();
    periph_in_type p;
    p = '0;
    wr(LATCH_OFS, 8'h00);
    wr(DIR_OFS, 8'hf7);
    p.spi_master = 1'b1; p.spi_sck = 1'b1;
    set_per(p);
    chk_reg({24'h0, pin_oe & pin_out}, 32'h08, "sck on bit 3");
    wr(DIR_OFS, 8'hff);
    drive(8'h08, 8'h08);
    chk_bit(periph_out.sck_in, 1'b1, "sck input");
    chk_bit(pin_oe[3], 1'b0, "bit 3 floats");
  endtask

  // low enable must hold the pins even while a peripheral changes
  task automatic t_freeze();
    periph_in_type p;
    p = '0;
    wr(DIR_OFS, 8'h00);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    p.osc_en = 1'b1;
    set_per(p);
    chk_reg({24'h0, pin_oe}, 32'hff, "enable low freezes pins");
    @(posedge sys_clk);
    clk_en <= 1'b1;
    settle();
    chk_reg({24'h0, pin_oe}, 32'hfc, "enable high resumes");
    set_per('0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle();
    t_reset();
    t_drive();
    t_latch();
    t_osc();
    t_cmp(1'b0);
    t_cmp(1'b1);
    t_pwm();
    t_spi();
    t_freeze();
    print_verdict();
  end
endmodule // port_c_gpio_with_pin_mux_bench
